// *** design/psfb_pkg.sv ***
// Package with command codes, bit positions, reset values and host register map of the status flag bank.
package psfb_pkg;
    // Command codes of the device registers.
    localparam logic [7:0] CMD_LIMIT = 8'h6b;
    localparam logic [7:0] CMD_SUM_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUM_WORD = 8'h79;
    localparam logic [7:0] CMD_IOUT_STAT = 8'h7b;
    localparam logic [7:0] CMD_INPUT_STAT = 8'h7c;
    localparam logic [7:0] CMD_COMM_STAT = 8'h7e;
    // Input overpower warning limit layout.
    localparam int LIMIT_LSB = 4;
    localparam int LIMIT_W = 12;
    localparam logic [11:0] LIMIT_RST = 12'hfff;
    // Summary byte and word bit positions.
    localparam int SB_OTHER = 0;
    localparam int SB_COMM = 1;
    localparam int SW_VENDOR = 12;
    localparam int SW_INPUT = 13;
    localparam int SW_IOUT = 14;
    localparam logic SW_VENDOR_RST = 1'b1;
    // Output current status bit.
    localparam int IO_OC_WARN = 5;
    // Input status bit positions.
    localparam int IN_OV_WARN = 6;
    localparam int IN_UV_WARN = 5;
    localparam int IN_OC_WARN = 1;
    localparam int IN_OP_WARN = 0;
    // Communication status bit positions.
    localparam int CM_BAD_CMD = 7;
    localparam int CM_PEC = 5;
    localparam int CM_MEM = 4;
    // Host register byte offsets on the Avalon-MM slave.
    localparam logic [4:0] HR_CTRL = 5'h00;
    localparam logic [4:0] HR_CODE = 5'h04;
    localparam logic [4:0] HR_WDATA = 5'h08;
    localparam logic [4:0] HR_STATUS = 5'h0c;
    localparam logic [4:0] HR_RDATA = 5'h10;
    // Host control bits.
    localparam int CT_GO = 0;
    localparam int CT_WR = 1;
    localparam int CT_CLR = 2;
    // Host status bits.
    localparam int ST_BUSY = 0;
    localparam int ST_ALERT = 1;
    // Host FSM states.
    typedef enum logic [0:0] {
        HS_IDLE = 1'b0,
        HS_WAIT = 1'b1
    } psfb_hstate_e;
endpackage : psfb_pkg

// *** design/psfb_if.sv ***
// Interface joining the host controller and the status flag bank.
`timescale 1ns/1ns
interface psfb_if;
    logic req;
    logic wr;
    logic [7:0] code;
    logic [15:0] wdata;
    logic clear_all;
    logic ack;
    logic [15:0] rdata;
    logic alert;
    modport dev (input req, input wr, input code, input wdata, input clear_all,
                 output ack, output rdata, output alert);
    modport host (output req, output wr, output code, output wdata, output clear_all,
                  input ack, input rdata, input alert);
endinterface : psfb_if

// *** design/psfb_dev.sv ***
// Status and warning flag bank of the monitor, reached through its command port.
//
// Overview of operation
// - Limit holds 12 bits 15:4, low nibble zero.
// - Summary byte read returns eight bits, two of them flags.
// - Summary bit 1 flags communication fault, resets 0.
// - Summary bit 0 is OR of four warnings.
// - Other-fault bit clears only via its contributors.
// - Clear-all clears flags once condition removed.
// - Summary word read returns sixteen bits.
// - Word bit 14 flags output current warning.
// - Word bit 13 flags any input warning.
// - Word bit 12 vendor fault, resets to 1.
// - Startup conflict resolved to tabulated zero defaults.
// - Word bits 15, 11:8 zero; low byte mirrors.
// - Output current status: only bit 5 live.
// - Current and input flags clear by write-one.
// - Input bits 6 overvoltage, 5 undervoltage warnings.
// - Input bits 1 overcurrent, 0 overpower; others zero.
// - Communication flags clear by write-one or clear-all.
// - Communication bit 7 on invalid command.
// - Communication bit 5 on PEC mismatch.
// - Communication bit 4 on memory fault.
// - Unmasked warnings raise the alert output.
// - Vendor communication fault bit ORs communication flags.
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module psfb_dev (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Command port to the host.
    psfb_if.dev bus,
    // Warning conditions from the comparators.
    input wire logic iout_oc_cond,
    input wire logic vin_ov_cond,
    input wire logic input_undervoltage_summary_cond,
    input wire logic iin_oc_cond,
    input wire logic pin_op_cond,
    input wire logic vendor_fault_cond,
    // Communication fault events from the bus interface.
    input wire logic bad_cmd_ev,
    input wire logic pec_fail_ev,
    input wire logic mem_fault_ev,
    // Alert mask, one bit per warning: iout, vin_ov, input_undervoltage_summary, iin_oc, pin_op.
    input wire logic [4:0] alert_mask,
    // Limit to the comparator and vendor summary bit.
    output logic [11:0] limit_q,
    output logic mfr_comm_fault_q
);
    logic ack_q;
    logic [15:0] rdata_q;
    logic alert_q;
    logic iout_oc_q;
    logic vin_ov_q;
    logic input_undervoltage_summary_q;
    logic iin_oc_q;
    logic pin_op_q;
    logic vendor_q;
    logic bad_cmd_q;
    logic pec_q;
    logic mem_q;

    // Set wins over clear.
    function automatic logic upd(input logic cur, input logic set, input logic clr);
        upd = set | (cur & ~clr);
    endfunction : upd

    // Puts one flag at its bit position in a status view.
    function automatic logic [7:0] place8(input logic flag, input int pos);
        place8 = {7'h0, flag} << pos;
    endfunction : place8

    function automatic logic [15:0] place16(input logic flag, input int pos);
        place16 = {15'h0, flag} << pos;
    endfunction : place16

    wire take = bus.req & ~ack_q;
    wire wr_take = take & bus.wr;
    wire hit_limit = bus.code == psfb_pkg::CMD_LIMIT;
    wire hit_byte = bus.code == psfb_pkg::CMD_SUM_BYTE;
    wire hit_word = bus.code == psfb_pkg::CMD_SUM_WORD;
    wire hit_iout = bus.code == psfb_pkg::CMD_IOUT_STAT;
    wire hit_input = bus.code == psfb_pkg::CMD_INPUT_STAT;
    wire hit_comm = bus.code == psfb_pkg::CMD_COMM_STAT;
    wire writable = hit_limit | hit_iout | hit_input | hit_comm;
    wire known = writable | hit_byte | hit_word;
    wire bad_cmd = take & (~known | (bus.wr & ~writable));
    wire [7:0] w1c_iout = (wr_take & hit_iout) ? bus.wdata[7:0] : 8'h00;
    wire [7:0] w1c_in = (wr_take & hit_input) ? bus.wdata[7:0] : 8'h00;
    wire [7:0] w1c_cm = (wr_take & hit_comm) ? bus.wdata[7:0] : 8'h00;
    wire clr = bus.clear_all;
    wire clr_iout_oc = clr | w1c_iout[psfb_pkg::IO_OC_WARN];
    wire clr_vin_ov = clr | w1c_in[psfb_pkg::IN_OV_WARN];
    wire clr_input_undervoltage_summary = clr | w1c_in[psfb_pkg::IN_UV_WARN];
    wire clr_iin_oc = clr | w1c_in[psfb_pkg::IN_OC_WARN];
    wire clr_pin_op = clr | w1c_in[psfb_pkg::IN_OP_WARN];
    wire clr_bad_cmd = clr | w1c_cm[psfb_pkg::CM_BAD_CMD];
    wire clr_pec = clr | w1c_cm[psfb_pkg::CM_PEC];
    wire clr_mem = clr | w1c_cm[psfb_pkg::CM_MEM];
    wire set_bad_cmd = bad_cmd_ev | bad_cmd;

    wire other_fault = iout_oc_q | vin_ov_q | input_undervoltage_summary_q | iin_oc_q;
    wire comm_fault = bad_cmd_q | pec_q | mem_q;
    wire input_sum = vin_ov_q | input_undervoltage_summary_q | iin_oc_q | pin_op_q;
    wire [7:0] sum_byte = place8(other_fault, psfb_pkg::SB_OTHER) |
                          place8(comm_fault, psfb_pkg::SB_COMM);
    wire [15:0] sum_word = place16(iout_oc_q, psfb_pkg::SW_IOUT) |
                           place16(input_sum, psfb_pkg::SW_INPUT) |
                           place16(vendor_q, psfb_pkg::SW_VENDOR) |
                           {8'h00, sum_byte};
    wire [7:0] iout_stat = place8(iout_oc_q, psfb_pkg::IO_OC_WARN);
    wire [7:0] input_stat = place8(vin_ov_q, psfb_pkg::IN_OV_WARN) |
                            place8(input_undervoltage_summary_q, psfb_pkg::IN_UV_WARN) |
                            place8(iin_oc_q, psfb_pkg::IN_OC_WARN) |
                            place8(pin_op_q, psfb_pkg::IN_OP_WARN);
    wire [7:0] comm_stat = place8(bad_cmd_q, psfb_pkg::CM_BAD_CMD) |
                           place8(pec_q, psfb_pkg::CM_PEC) |
                           place8(mem_q, psfb_pkg::CM_MEM);
    wire [15:0] limit_rd = {4'h0, limit_q} << psfb_pkg::LIMIT_LSB;
    wire [15:0] rd_sel = hit_limit ? limit_rd :
                         hit_word ? sum_word :
                         hit_byte ? {8'h00, sum_byte} :
                         hit_iout ? {8'h00, iout_stat} :
                         hit_input ? {8'h00, input_stat} :
                         hit_comm ? {8'h00, comm_stat} : 16'h0000;
    wire [4:0] warn_vec = {iout_oc_q, vin_ov_q, input_undervoltage_summary_q, iin_oc_q, pin_op_q};
    wire alert_d = |(warn_vec & ~alert_mask);

    assign bus.ack = ack_q;
    assign bus.rdata = rdata_q;
    assign bus.alert = alert_q;

    // Link answer and read data.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ack_q <= 1'b0;
            rdata_q <= 16'h0000;
        end else begin
            ack_q <= take;
            if (take) begin
                rdata_q <= rd_sel;
            end
        end
    end

    // Input overpower warning limit.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            limit_q <= psfb_pkg::LIMIT_RST;
        end else if (wr_take & hit_limit) begin
            limit_q <= bus.wdata[psfb_pkg::LIMIT_LSB +: psfb_pkg::LIMIT_W];
        end
    end

    // Alert and vendor communication fault summary.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            alert_q <= 1'b0;
            mfr_comm_fault_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
            mfr_comm_fault_q <= comm_fault;
        end
    end

    // Output current warning flag.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            iout_oc_q <= 1'b0;
        end else begin
            iout_oc_q <= upd(iout_oc_q, iout_oc_cond, clr_iout_oc);
        end
    end

    // Input warning flags; undervoltage starts at zero.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            vin_ov_q <= 1'b0;
            input_undervoltage_summary_q <= 1'b0;
            iin_oc_q <= 1'b0;
            pin_op_q <= 1'b0;
        end else begin
            vin_ov_q <= upd(vin_ov_q, vin_ov_cond, clr_vin_ov);
            input_undervoltage_summary_q <= upd(input_undervoltage_summary_q, input_undervoltage_summary_cond, clr_input_undervoltage_summary);
            iin_oc_q <= upd(iin_oc_q, iin_oc_cond, clr_iin_oc);
            pin_op_q <= upd(pin_op_q, pin_op_cond, clr_pin_op);
        end
    end

    // Vendor summary flag; starts set and clears only by clear-all.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            vendor_q <= psfb_pkg::SW_VENDOR_RST;
        end else begin
            vendor_q <= upd(vendor_q, vendor_fault_cond, clr);
        end
    end

    // Communication fault flags.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bad_cmd_q <= 1'b0;
            pec_q <= 1'b0;
            mem_q <= 1'b0;
        end else begin
            bad_cmd_q <= upd(bad_cmd_q, set_bad_cmd, clr_bad_cmd);
            pec_q <= upd(pec_q, pec_fail_ev, clr_pec);
            mem_q <= upd(mem_q, mem_fault_ev, clr_mem);
        end
    end
endmodule : psfb_dev

// *** design/psfb_host.sv ***
// Host controller that turns Avalon-MM register orders into status bank transactions.
`timescale 1ns/1ns
module psfb_host (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Avalon-MM slave.
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Command port to the status bank.
    psfb_if.host bus
);
    psfb_pkg::psfb_hstate_e state_q;
    logic req_q;
    logic wr_q;
    logic clr_q;
    logic [7:0] code_q;
    logic [15:0] wdata_q;
    logic [15:0] result_q;
    logic [31:0] readdata_q;
    logic wait_q;

    wire access = (avs_read | avs_write) & wait_q;
    wire commit = avs_write & ~wait_q;
    wire ctrl_wr = commit & (avs_address == psfb_pkg::HR_CTRL);
    wire go = ctrl_wr & avs_writedata[psfb_pkg::CT_GO] & (state_q == psfb_pkg::HS_IDLE);
    wire busy = state_q == psfb_pkg::HS_WAIT;
    wire [31:0] status_rd = {30'h0, bus.alert, busy};
    wire [31:0] rd_sel = (avs_address == psfb_pkg::HR_CODE) ? {24'h0, code_q} :
                         (avs_address == psfb_pkg::HR_WDATA) ? {16'h0, wdata_q} :
                         (avs_address == psfb_pkg::HR_STATUS) ? status_rd :
                         (avs_address == psfb_pkg::HR_RDATA) ? {16'h0, result_q} : 32'h0;

    assign avs_readdata = readdata_q;
    assign avs_waitrequest = wait_q;
    assign bus.req = req_q;
    assign bus.wr = wr_q;
    assign bus.code = code_q;
    assign bus.wdata = wdata_q;
    assign bus.clear_all = clr_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wait_q <= 1'b1;
            readdata_q <= 32'h0;
        end else begin
            wait_q <= ~access;
            if (access) begin
                readdata_q <= avs_read ? rd_sel : 32'h0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_q <= 8'h00;
            wdata_q <= 16'h0000;
            clr_q <= 1'b0;
        end else begin
            if (commit & (avs_address == psfb_pkg::HR_CODE)) begin
                code_q <= avs_writedata[7:0];
            end
            if (commit & (avs_address == psfb_pkg::HR_WDATA)) begin
                wdata_q <= avs_writedata[15:0];
            end
            clr_q <= ctrl_wr & avs_writedata[psfb_pkg::CT_CLR];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_q <= psfb_pkg::HS_IDLE;
            req_q <= 1'b0;
            wr_q <= 1'b0;
            result_q <= 16'h0000;
        end else begin
            case (state_q)
                psfb_pkg::HS_IDLE: begin
                    if (go) begin
                        req_q <= 1'b1;
                        wr_q <= avs_writedata[psfb_pkg::CT_WR];
                        state_q <= psfb_pkg::HS_WAIT;
                    end
                end
                psfb_pkg::HS_WAIT: begin
                    if (bus.ack) begin
                        req_q <= 1'b0;
                        result_q <= bus.rdata;
                        state_q <= psfb_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state_q <= psfb_pkg::HS_IDLE;
                    req_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : psfb_host

// *** verif/psfb_assertions.sv ***
// Checker of the command link between the host controller and the flag bank.
`timescale 1ns/1ns
module psfb_assertions (
    // Clock and reset.
    input logic clk,
    input logic resetn,
    // Link signals.
    input logic req,
    input logic wr,
    input logic [7:0] code,
    input logic ack,
    input logic [15:0] rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire rb = ack && !wr;
    ack_delay_a: assert property (req && !ack |=> ack) else $error("ack late");
    ack_pulse_a: assert property (ack |=> !ack) else $error("ack long");
    byte_unused_a: assert property (rb && code == psfb_pkg::CMD_SUM_BYTE |-> rdata[15:2] == 14'h0000)
        else $error("byte spare bits set");
    word_unused_a: assert property (rb && code == psfb_pkg::CMD_SUM_WORD |-> !rdata[15] && rdata[11:8] == 4'h0)
        else $error("word spare bits set");
    word_other_a: assert property (rb && code == psfb_pkg::CMD_SUM_WORD && rdata[14] |-> rdata[0])
        else $error("other fault missing");
    iout_bits_a: assert property (rb && code == psfb_pkg::CMD_IOUT_STAT |-> (rdata & 16'hffdf) == 16'h0000)
        else $error("current status spare bits");
    input_bits_a: assert property (rb && code == psfb_pkg::CMD_INPUT_STAT |-> (rdata & 16'hff9c) == 16'h0000)
        else $error("input status spare bits");
    comm_bits_a: assert property (rb && code == psfb_pkg::CMD_COMM_STAT |-> (rdata & 16'hff4f) == 16'h0000)
        else $error("comm status spare bits");
    limit_low_a: assert property (rb && code == psfb_pkg::CMD_LIMIT |-> rdata[3:0] == 4'h0)
        else $error("limit low bits set");
endmodule : psfb_assertions

// *** verif/pmbus_status_flag_bank_test.sv ***
// Self-checking bench for the host controller and flag bank pair.
`timescale 1ns/1ns
module pmbus_status_flag_bank_test;
    logic clk, resetn, avs_read, avs_write, avs_waitrequest, vendor_fault_summary;
    logic [4:0] avs_address, mask;
    logic [31:0] avs_writedata, avs_readdata, rd, v, seed = 32'h7872;
    logic [5:0] cnd;
    logic [2:0] ev;
    logic [11:0] limit_q, e_lim = 12'hfff;
    logic [7:0] e_io = 8'h00, e_in = 8'h00, e_cm = 8'h00;
    logic e_vd = 1'b1;
    logic [15:0] r;
    logic [7:0] cs [6] = '{psfb_pkg::CMD_LIMIT, psfb_pkg::CMD_SUM_BYTE, psfb_pkg::CMD_SUM_WORD,
        psfb_pkg::CMD_IOUT_STAT, psfb_pkg::CMD_INPUT_STAT, psfb_pkg::CMD_COMM_STAT};
    int n_fail = 0, n_checks = 0, cyc = 0;
    psfb_if lnk ();
    psfb_host psfb_host_inst (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus(lnk.host));
    psfb_dev psfb_dev_inst (.clk(clk), .resetn(resetn), .bus(lnk.dev), .iout_oc_cond(cnd[4]),
        .vin_ov_cond(cnd[3]), .input_undervoltage_summary_cond(cnd[2]), .iin_oc_cond(cnd[1]), .pin_op_cond(cnd[0]),
        .vendor_fault_cond(cnd[5]), .bad_cmd_ev(ev[2]), .pec_fail_ev(ev[1]), .mem_fault_ev(ev[0]),
        .alert_mask(mask), .limit_q(limit_q), .mfr_comm_fault_q(vendor_fault_summary));
    psfb_assertions psfb_assertions_inst (.clk(clk), .resetn(resetn), .req(lnk.req), .wr(lnk.wr),
        .code(lnk.code), .ack(lnk.ack), .rdata(lnk.rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            end_sim();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [15:0] ex(input logic [7:0] c);
        logic [7:0] b;
        b = {6'h00, |e_cm, e_io[5] | e_in[6] | e_in[5] | e_in[1]};
        case (c)
            psfb_pkg::CMD_LIMIT: ex = {e_lim, 4'h0};
            psfb_pkg::CMD_SUM_BYTE: ex = {8'h00, b};
            psfb_pkg::CMD_SUM_WORD: ex = {1'b0, e_io[5], |e_in, e_vd, 4'h0, b};
            psfb_pkg::CMD_IOUT_STAT: ex = {8'h00, e_io};
            psfb_pkg::CMD_INPUT_STAT: ex = {8'h00, e_in};
            default: ex = {8'h00, e_cm};
        endcase
    endfunction : ex
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    task automatic dv(input logic [7:0] c, input logic w, input logic [15:0] d, output logic [15:0] q);
        av(1'b1, psfb_pkg::HR_CODE, {24'h000000, c});
        av(1'b1, psfb_pkg::HR_WDATA, {16'h0000, d});
        av(1'b1, psfb_pkg::HR_CTRL, {30'h00000000, w, 1'b1});
        rd = 32'h00000001;
        while (rd[0] !== 1'b0) av(1'b0, psfb_pkg::HR_STATUS, 32'h00000000);
        av(1'b0, psfb_pkg::HR_RDATA, 32'h00000000);
        q = rd[15:0];
    endtask : dv
    task automatic rdall();
        for (int i = 0; i < 6; i++) begin
            dv(cs[i], 1'b0, 16'h0000, r);
            chk(r, ex(cs[i]));
        end
        chk({4'h0, limit_q}, {4'h0, e_lim});
    endtask : rdall
    task automatic setm();
        e_io[5] |= cnd[4];
        e_in |= {1'b0, cnd[3:2], 3'h0, cnd[1:0]};
        e_vd |= cnd[5];
    endtask : setm
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim
    initial begin
        resetn = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, cnd, ev, mask} = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        rdall();
        av(1'b0, 5'h1c, 32'h00000000);
        chk(rd[15:0], 16'h0000);
        repeat (30) begin
            v = rnd();
            cnd <= v[5:0];
            ev <= v[8:6];
            mask <= v[13:9];
            @(posedge clk);
            ev <= 3'h0;
            e_cm |= {v[8], 1'b0, v[7:6], 4'h0};
            dv(psfb_pkg::CMD_LIMIT, 1'b1, v[31:16], r);
            e_lim = v[31:20];
            setm();
            rdall();
            chk(16'(lnk.alert), 16'(|({e_io[5], e_in[6:5], e_in[1:0]} & ~mask)));
            chk(16'(vendor_fault_summary), 16'(|e_cm));
            av(1'b0, psfb_pkg::HR_STATUS, 32'h00000000);
            chk(16'(rd[psfb_pkg::ST_ALERT]), 16'(|({e_io[5], e_in[6:5], e_in[1:0]} & ~mask)));
            if (v[14]) begin
                av(1'b1, psfb_pkg::HR_CTRL, 32'h00000004);
                {e_io, e_in, e_cm, e_vd} = '0;
            end else if (v[15]) begin
                dv(psfb_pkg::CMD_COMM_STAT, 1'b1, {8'h00, v[23:16]}, r);
                e_cm &= ~v[23:16];
            end else begin
                dv(v[16] ? psfb_pkg::CMD_INPUT_STAT : psfb_pkg::CMD_IOUT_STAT, 1'b1, {8'h00, v[23:16]}, r);
                if (v[16]) e_in &= ~v[23:16];
                else e_io &= ~v[23:16];
            end
            repeat (2) @(posedge clk);
            setm();
            rdall();
        end
        for (int i = 0; i < 2; i++) begin
            dv(i ? psfb_pkg::CMD_SUM_WORD : 8'h00, i[0], 16'hffff, r);
            e_cm[7] = 1'b1;
            rdall();
            dv(psfb_pkg::CMD_COMM_STAT, 1'b1, 16'h0080, r);
            e_cm[7] = 1'b0;
        end
        rdall();
        end_sim();
    end
endmodule : pmbus_status_flag_bank_test
